// ===== sile_top.sv
// Purpose: powerup start interlock and parameter edit lock
// Assumes: RST is applied at each power-on; terminals are asynchronous
// Notes: keypad reset pulse is synchronous to REF_CLK
`include "sile_regs.svh"
module sile_top
    import sile_pkg::*;
#(
    parameter int unsigned CLR_MIN_CYC = `SILE_CLR_MIN_CYC
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // control terminals
    input wire logic RUN_CMD,
    input wire logic FAULT_CLEAR_INPUT,
    input wire logic POWERUP_START_INTERLOCK,
    input wire logic PARAMETER_EDIT_LOCK,
    // keypad and settings
    input wire logic KEYPAD_RESET,
    input wire logic LOCK_SCOPE_SETTING,
    // edit requests
    input wire logic KEYPAD_EDIT_REQ,
    input wire logic REMOTE_EDIT_REQ,
    input wire logic EDIT_IS_FREQ,
    // status
    output logic MOTOR_RUN,
    output logic ALARM,
    output logic [7:0] ERROR_CODE,
    output logic EDIT_ACCEPT,
    output logic EDIT_REJECT,
    output logic PARAM_WRITE_EN,
    output logic FREQ_WRITE_EN
);

    sile_all_type s_reg;
    sile_all_type s_next;
    logic clr_release;
    logic reset_any;
    logic edit_req;
    logic edit_ok;

    ////////////////////////////////////////////////////////////////////
    // combinational next state

    always_comb begin
        s_next = s_reg;
        // change counts once stages two and three agree
        s_next.run_sync = {s_reg.run_sync[1:0], RUN_CMD};
        s_next.clr_sync = {s_reg.clr_sync[1:0], FAULT_CLEAR_INPUT};
        s_next.il_sync = {s_reg.il_sync[1:0], POWERUP_START_INTERLOCK};
        s_next.el_sync = {s_reg.el_sync[1:0], PARAMETER_EDIT_LOCK};
        if (s_reg.run_sync[2] == s_reg.run_sync[1]) begin
            s_next.run_f = s_reg.run_sync[2];
        end
        if (s_reg.clr_sync[2] == s_reg.clr_sync[1]) begin
            s_next.clr_f = s_reg.clr_sync[2];
        end
        if (s_reg.il_sync[2] == s_reg.il_sync[1]) begin
            s_next.il_f = s_reg.il_sync[2];
        end
        if (s_reg.el_sync[2] == s_reg.el_sync[1]) begin
            s_next.el_f = s_reg.el_sync[2];
        end
        // pulse width measured while held; release fires the reset
        if (s_reg.clr_f) begin
            if (s_reg.clr_cnt >= `SILE_CNT_W'(CLR_MIN_CYC - 1)) begin
                s_next.clr_long = 1'b1;
            end else begin
                s_next.clr_cnt = s_reg.clr_cnt + `SILE_CNT_W'(1);
            end
        end else begin
            s_next.clr_cnt = '0;
            s_next.clr_long = 1'b0;
        end
        case (s_reg.state)
            SILE_POWERUP: begin
                // wait for filters to settle before one-shot check
                if (s_reg.checked) begin
                    s_next.checked = 1'b0;
                    if (s_reg.run_f && s_reg.il_f) begin
                        s_next.state = SILE_TRIP;
                        s_next.alarm = 1'b1;
                        s_next.err = `SILE_ERR_INTERLOCK;
                    end else if (s_reg.run_f) begin
                        s_next.state = SILE_RUN;
                        s_next.run_out = 1'b1;
                    end else begin
                        s_next.state = SILE_STOP;
                    end
                end else if (s_reg.run_sync[2] == s_reg.run_sync[1]
                    && s_reg.il_sync[2] == s_reg.il_sync[1]) begin
                    s_next.checked = 1'b1;
                end
            end
            SILE_STOP: begin
                // later run commands never trip again
                if (s_reg.run_f) begin
                    s_next.state = SILE_RUN;
                    s_next.run_out = 1'b1;
                end
            end
            SILE_RUN: begin
                if (!s_reg.run_f) begin
                    s_next.state = SILE_STOP;
                    s_next.run_out = 1'b0;
                end else if (reset_any) begin
                    s_next.state = SILE_RUN;
                end
            end
            SILE_TRIP: begin
                if (!s_reg.run_f) begin
                    s_next.state = SILE_STOP;
                    s_next.alarm = 1'b0;
                    s_next.err = `SILE_ERR_NONE;
                end else if (reset_any) begin
                    // run still active: resume at once
                    s_next.state = SILE_RUN;
                    s_next.run_out = 1'b1;
                    s_next.alarm = 1'b0;
                    s_next.err = `SILE_ERR_NONE;
                end
            end
            default: begin
                s_next.state = SILE_STOP;
                s_next.run_out = 1'b0;
            end
        endcase
        // edit lock; frequency exempt only when scope bit low
        s_next.write_ok = edit_req && !s_reg.el_f && !EDIT_IS_FREQ;
        s_next.freq_ok = edit_req && EDIT_IS_FREQ
            && (!s_reg.el_f || !LOCK_SCOPE_SETTING);
    end

    assign clr_release = s_reg.clr_long && !s_reg.clr_f
        && s_reg.clr_sync[2] == s_reg.clr_sync[1];
    assign reset_any = clr_release || KEYPAD_RESET;
    assign edit_req = KEYPAD_EDIT_REQ || REMOTE_EDIT_REQ;
    assign edit_ok = !s_reg.el_f
        || (EDIT_IS_FREQ && !LOCK_SCOPE_SETTING);

    ////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            s_reg <= '0;
            s_reg.state <= SILE_POWERUP;
            // run and interlock filters keep sampling through reset:
            // a cleared chain looks settled and hides a held run
            s_reg.run_sync <= s_next.run_sync;
            s_reg.run_f <= s_next.run_f;
            s_reg.il_sync <= s_next.il_sync;
            s_reg.il_f <= s_next.il_f;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign MOTOR_RUN = s_reg.run_out;
    assign ALARM = s_reg.alarm;
    assign ERROR_CODE = s_reg.err;
    assign EDIT_ACCEPT = edit_req && edit_ok;
    assign EDIT_REJECT = edit_req && !edit_ok;
    assign PARAM_WRITE_EN = s_reg.write_ok;
    assign FREQ_WRITE_EN = s_reg.freq_ok;

    ////////////////////////////////////////////////////////////////////
    // checks

    property p_lock_blocks;
        @(posedge REF_CLK) disable iff (RST)
        s_reg.el_f && KEYPAD_EDIT_REQ && !EDIT_IS_FREQ |-> EDIT_REJECT;
    endproperty
    a_lock_blocks: assert property (p_lock_blocks)
        else $error("edit accepted while locked");

    property p_unlocked_ok;
        @(posedge REF_CLK) disable iff (RST)
        !s_reg.el_f && REMOTE_EDIT_REQ |-> EDIT_ACCEPT;
    endproperty
    a_unlocked_ok: assert property (p_unlocked_ok)
        else $error("edit refused while unlocked");

    property p_write_follows;
        @(posedge REF_CLK) disable iff (RST)
        KEYPAD_EDIT_REQ && !EDIT_IS_FREQ && !s_reg.el_f
            |=> PARAM_WRITE_EN;
    endproperty
    a_write_follows: assert property (p_write_follows)
        else $error("unlocked edit not written");

    property p_scope;
        @(posedge REF_CLK) disable iff (RST)
        s_reg.el_f && EDIT_IS_FREQ && KEYPAD_EDIT_REQ
            |-> EDIT_ACCEPT == !LOCK_SCOPE_SETTING;
    endproperty
    a_scope: assert property (p_scope)
        else $error("frequency exemption wrong");

    property p_trip_code;
        @(posedge REF_CLK) disable iff (RST)
        s_reg.state == SILE_TRIP |-> ALARM && !MOTOR_RUN
            && ERROR_CODE == `SILE_ERR_INTERLOCK;
    endproperty
    a_trip_code: assert property (p_trip_code)
        else $error("trip without stop and code");

    property p_trip_entry;
        @(posedge REF_CLK) disable iff (RST)
        s_reg.state == SILE_POWERUP && s_reg.checked && s_reg.run_f
            && s_reg.il_f |=> s_reg.state == SILE_TRIP;
    endproperty
    a_trip_entry: assert property (p_trip_entry)
        else $error("interlock did not trip");

    property p_free_start;
        @(posedge REF_CLK) disable iff (RST)
        s_reg.state == SILE_POWERUP && s_reg.checked && s_reg.run_f
            && !s_reg.il_f |=> MOTOR_RUN;
    endproperty
    a_free_start: assert property (p_free_start)
        else $error("powerup run not started");

    property p_resume;
        @(posedge REF_CLK) disable iff (RST)
        s_reg.state == SILE_TRIP && s_reg.run_f && reset_any
            |=> MOTOR_RUN && !ALARM;
    endproperty
    a_resume: assert property (p_resume)
        else $error("reset did not resume run");

    property p_drop_clears;
        @(posedge REF_CLK) disable iff (RST)
        s_reg.state == SILE_TRIP && !s_reg.run_f
            |=> !ALARM && !MOTOR_RUN;
    endproperty
    a_drop_clears: assert property (p_drop_clears)
        else $error("run drop did not clear");

    property p_once;
        @(posedge REF_CLK) disable iff (RST)
        s_reg.state != SILE_POWERUP && s_reg.state != SILE_TRIP
            |=> s_reg.state != SILE_TRIP;
    endproperty
    a_once: assert property (p_once)
        else $error("late interlock trip");

    property p_short_clear;
        @(posedge REF_CLK) disable iff (RST)
        $fell(s_reg.clr_f) && $past(s_reg.clr_cnt) < CLR_MIN_CYC - 1
            |-> !clr_release;
    endproperty
    a_short_clear: assert property (p_short_clear)
        else $error("short reset pulse accepted");

    property p_stop_holds;
        @(posedge REF_CLK) disable iff (RST)
        s_reg.state == SILE_STOP && !s_reg.run_f
            |=> !MOTOR_RUN && !ALARM;
    endproperty
    a_stop_holds: assert property (p_stop_holds)
        else $error("stopped output started without run");

    property p_alarm_clear;
        @(posedge REF_CLK) disable iff (RST)
        s_reg.state == SILE_TRIP && clr_release |=> !ALARM;
    endproperty
    a_alarm_clear: assert property (p_alarm_clear)
        else $error("terminal reset left alarm on");

    property p_lock_write;
        @(posedge REF_CLK) disable iff (RST)
        s_reg.el_f && edit_req && !EDIT_IS_FREQ |=> !PARAM_WRITE_EN;
    endproperty
    a_lock_write: assert property (p_lock_write)
        else $error("parameter written while locked");

    property p_freq_locked;
        @(posedge REF_CLK) disable iff (RST)
        s_reg.el_f && LOCK_SCOPE_SETTING && edit_req
            |=> !FREQ_WRITE_EN;
    endproperty
    a_freq_locked: assert property (p_freq_locked)
        else $error("frequency written under full lock");

    property p_freq_free;
        @(posedge REF_CLK) disable iff (RST)
        !s_reg.el_f && REMOTE_EDIT_REQ && EDIT_IS_FREQ
            |=> FREQ_WRITE_EN;
    endproperty
    a_freq_free: assert property (p_freq_free)
        else $error("unlocked frequency edit not written");

    property p_quiet;
        @(posedge REF_CLK) disable iff (RST)
        s_reg.state != SILE_TRIP
            |-> !ALARM && ERROR_CODE == `SILE_ERR_NONE;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("alarm or code outside trip");

endmodule : sile_top

// ===== sile_regs.svh
`ifndef SILE_REGS_SVH
`define SILE_REGS_SVH
// Purpose: constants of the start interlock and edit lock block
// Assumes: REF_CLK at 40 MHz
// Notes: times in microseconds, counts derived from them
`define SILE_CLK_MHZ 40
`define SILE_CLR_MIN_US 12000
`define SILE_CLR_MIN_CYC (`SILE_CLR_MIN_US * `SILE_CLK_MHZ)
`define SILE_CNT_W 20
`define SILE_FUNC_INTERLOCK 8'h0D
`define SILE_FUNC_EDIT_LOCK 8'h0F
`define SILE_ERR_INTERLOCK 8'h0D
`define SILE_ERR_NONE 8'h00
`endif

// ===== sile_pkg.sv
// Purpose: types of the start interlock and edit lock block
// Assumes: nothing beyond sile_regs.svh
// Notes: run state is one-hot
`include "sile_regs.svh"
package sile_pkg;
    typedef enum logic [3:0] {
        SILE_POWERUP = 4'h1,
        SILE_STOP = 4'h2,
        SILE_RUN = 4'h4,
        SILE_TRIP = 4'h8
    } sile_state_type;
    typedef struct packed {
        sile_state_type state;
        logic [2:0] run_sync;
        logic [2:0] clr_sync;
        logic [2:0] il_sync;
        logic [2:0] el_sync;
        logic run_f;
        logic clr_f;
        logic il_f;
        logic el_f;
        logic checked;
        logic [`SILE_CNT_W-1:0] clr_cnt;
        logic clr_long;
        logic run_out;
        logic alarm;
        logic [7:0] err;
        logic write_ok;
        logic freq_ok;
    } sile_all_type;
endpackage : sile_pkg

// ===== sile_term_model.sv
// Purpose: terminal and keypad reset side of the interlock block
// Assumes: bench calls the tasks from its own process
// Notes: terminals change just after a clock edge
module sile_term_model (
    // clock
    input wire logic clk,
    // terminals
    output logic run_cmd,
    output logic fault_clear,
    output logic interlock,
    output logic edit_lock,
    output logic keypad_reset
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        run_cmd = 1'h0;
        fault_clear = 1'h0;
        interlock = 1'h0;
        edit_lock = 1'h0;
        keypad_reset = 1'h0;
    end
    ////////////////////////////////////////////////////////////////////
    task drive(input logic r, input logic il, input logic el);
        @(posedge clk);
        run_cmd <= r;
        interlock <= il;
        edit_lock <= el;
    endtask : drive
    // terminal reset; released line is off, not held
    task clear(input int n);
        @(posedge clk);
        fault_clear <= 1'h1;
        repeat (n) @(posedge clk);
        fault_clear <= 1'h0;
    endtask : clear
    task key();
        @(posedge clk);
        keypad_reset <= 1'h1;
        @(posedge clk);
        keypad_reset <= 1'h0;
    endtask : key
endmodule : sile_term_model

// ===== tb_top.sv
// Purpose: self-checking bench of the interlock and edit lock
// Assumes: clear pulse minimum shortened to 20 cycles
// Notes: edit cases in a table, powerup cases by hand
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic lk, sc, fq, rm, acc;
    } sile_row_type;
    logic REF_CLK = 1'h0, RST = 1'h1, LOCK_SCOPE_SETTING = 1'h0;
    logic KEYPAD_EDIT_REQ = 1'h0, REMOTE_EDIT_REQ = 1'h0;
    logic EDIT_IS_FREQ = 1'h0;
    logic run, clr, il, el, key, MOTOR_RUN, ALARM, acc, rej, pw, fw;
    logic [7:0] code;
    int error_cnt = 0;
    int compares = 0;
    sile_row_type rows [6] = '{5'h01, 5'h0F, 5'h10, 5'h15, 5'h1E, 5'h1A};
    always #12.5 REF_CLK = !REF_CLK;
    sile_term_model i_sile_term_model (.clk(REF_CLK), .run_cmd(run),
        .fault_clear(clr), .interlock(il), .edit_lock(el),
        .keypad_reset(key));
    sile_top #(.CLR_MIN_CYC(20)) i_sile_top (.REF_CLK(REF_CLK),
        .RST(RST), .RUN_CMD(run), .FAULT_CLEAR_INPUT(clr),
        .POWERUP_START_INTERLOCK(il), .PARAMETER_EDIT_LOCK(el),
        .KEYPAD_RESET(key), .LOCK_SCOPE_SETTING(LOCK_SCOPE_SETTING),
        .KEYPAD_EDIT_REQ(KEYPAD_EDIT_REQ),
        .REMOTE_EDIT_REQ(REMOTE_EDIT_REQ), .EDIT_IS_FREQ(EDIT_IS_FREQ),
        .MOTOR_RUN(MOTOR_RUN), .ALARM(ALARM), .ERROR_CODE(code),
        .EDIT_ACCEPT(acc), .EDIT_REJECT(rej), .PARAM_WRITE_EN(pw),
        .FREQ_WRITE_EN(fw));
    ////////////////////////////////////////////////////////////////////
    task chk1(input logic got, input logic exp, input string m);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t %s got %b", $time, m, got);
        end
    endtask : chk1
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t code got %h", $time, got);
        end
    endtask : chk8
    task wt(input int n);
        repeat (n) @(posedge REF_CLK);
        @(negedge REF_CLK);
    endtask : wt
    // each power-on is a full reset with terminals already settled
    task pwr(input logic r, input logic i);
        i_sile_term_model.drive(r, i, 1'h0);
        RST <= 1'h1;
        repeat (20) @(posedge REF_CLK);
        RST <= 1'h0;
        wt(12);
    endtask : pwr
    task final_report();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge REF_CLK);
        RST <= 1'h0;
        foreach (rows[i]) begin
            i_sile_term_model.drive(1'h0, 1'h0, rows[i].lk);
            repeat (8) @(posedge REF_CLK);
            LOCK_SCOPE_SETTING <= rows[i].sc;
            EDIT_IS_FREQ <= rows[i].fq;
            KEYPAD_EDIT_REQ <= !rows[i].rm;
            REMOTE_EDIT_REQ <= rows[i].rm;
            @(negedge REF_CLK);
            chk1(acc, rows[i].acc, "accept");
            chk1(rej, !rows[i].acc, "reject");
            @(posedge REF_CLK);
            KEYPAD_EDIT_REQ <= 1'h0;
            REMOTE_EDIT_REQ <= 1'h0;
            @(negedge REF_CLK);
            chk1(rows[i].fq ? fw : pw, rows[i].acc, "write");
            chk1(rows[i].fq ? pw : fw, 1'h0, "other write");
        end
        $display("edit table done");
        pwr(1'h1, 1'h0);
        chk1(MOTOR_RUN, 1'h1, "free run");
        chk1(ALARM, 1'h0, "free alarm");
        pwr(1'h1, 1'h1);
        chk1(MOTOR_RUN, 1'h0, "held run");
        chk1(ALARM, 1'h1, "trip");
        chk8(code, 8'h0D);
        i_sile_term_model.drive(1'h0, 1'h1, 1'h0);
        wt(10);
        chk1(ALARM, 1'h0, "drop clears");
        chk1(MOTOR_RUN, 1'h0, "stays off");
        i_sile_term_model.drive(1'h1, 1'h1, 1'h0);
        wt(10);
        chk1(MOTOR_RUN, 1'h1, "rerun");
        chk1(ALARM, 1'h0, "no late trip");
        $display("powerup done");
        pwr(1'h1, 1'h1);
        i_sile_term_model.clear(5);
        wt(10);
        chk1(ALARM, 1'h1, "short clear");
        i_sile_term_model.clear(30);
        wt(6);
        chk1(MOTOR_RUN, 1'h1, "resume");
        chk1(ALARM, 1'h0, "alarm off");
        chk8(code, 8'h00);
        pwr(1'h1, 1'h1);
        i_sile_term_model.key();
        wt(4);
        chk1(MOTOR_RUN, 1'h1, "key resume");
        chk1(ALARM, 1'h0, "key alarm");
        $display("reset paths done");
        final_report();
    end
endmodule : tb_top
